// [core/dpr_block_ram.sv]
// Purpose: True dual-port synchronous block memory with two independent ports
// Assumes: Both ports share clk; inputs synchronous to clk
// Notes:   Memory cells are not reset; only the port outputs are
`timescale 1ns/10ps
`default_nettype none

module dpr_block_ram
  import dpr_pkg::*;
#(
  parameter int unsigned WIDTH_A = WIDTH_A_D,
  parameter int unsigned WIDTH_B = WIDTH_B_D,
  parameter dprMode_t    MODE_A  = DPR_READ_WRITE,
  parameter dprMode_t    MODE_B  = DPR_READ_WRITE
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire dprReq_t            reqA,
  input  wire dprReq_t            reqB,
  output var  logic [WIDTH_A-1:0] doutA,
  output var  logic [WIDTH_B-1:0] doutB
);

  localparam int unsigned LG_A = $clog2(WIDTH_A);
  localparam int unsigned LG_B = $clog2(WIDTH_B);

  // Bit offset of a word address for a port of width 2**lg
  function automatic logic [ADDR_W-1:0] baseBit(input logic [ADDR_W-1:0] a,
                                                input int unsigned       lg);
    baseBit = ADDR_W'(a << lg);
  endfunction

  logic [MEM_BITS-1:0] mem_r;
  logic [WIDTH_A-1:0]  doutA_r;
  logic [WIDTH_B-1:0]  doutB_r;

  // Port function decoding
  wire logic canWrA = (MODE_A != DPR_READ_ONLY);
  wire logic canRdA = (MODE_A != DPR_WRITE_ONLY);
  wire logic canWrB = (MODE_B != DPR_READ_ONLY);
  wire logic canRdB = (MODE_B != DPR_WRITE_ONLY);

  wire logic wrA = reqA.en & reqA.we & canWrA;
  wire logic wrB = reqB.en & reqB.we & canWrB;
  wire logic rdA = reqA.en & ~wrA & canRdA;
  wire logic rdB = reqB.en & ~wrB & canRdB;

  wire logic [ADDR_W-1:0]  baseA  = baseBit(reqA.addr, LG_A);
  wire logic [ADDR_W-1:0]  baseB  = baseBit(reqB.addr, LG_B);
  wire logic [WIDTH_A-1:0] dinA   = reqA.din[WIDTH_A-1:0];
  wire logic [WIDTH_B-1:0] dinB   = reqB.din[WIDTH_B-1:0];
  wire logic [WIDTH_A-1:0] rdWordA = mem_r[baseA +: WIDTH_A];
  wire logic [WIDTH_B-1:0] rdWordB = mem_r[baseB +: WIDTH_B];

  // Write-only ports mirror nothing and keep their output
  wire logic mirA = wrA & canRdA;
  wire logic mirB = wrB & canRdB;

  // Cell array, written on one edge; port B lands last on a collision
  always_ff @(posedge clk) begin
    if (wrA) begin
      mem_r[baseA +: WIDTH_A] <= dinA;
    end
    if (wrB) begin
      mem_r[baseB +: WIDTH_B] <= dinB;
    end
  end

  // Port A output register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      doutA_r <= DOUT_RST[WIDTH_A-1:0];
    end else if (mirA) begin
      doutA_r <= dinA;
    end else if (rdA) begin
      doutA_r <= rdWordA;
    end
  end

  // Port B output register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      doutB_r <= DOUT_RST[WIDTH_B-1:0];
    end else if (mirB) begin
      doutB_r <= dinB;
    end else if (rdB) begin
      doutB_r <= rdWordB;
    end
  end

  // Outputs only from flip-flops, held between accesses
  assign doutA = doutA_r;
  assign doutB = doutB_r;

  // Assertions
  property p_wr_mirror;
    @(posedge clk) disable iff (!rst_b)
      mirA |=> doutA == $past(dinA);
  endproperty
  a_wr_mirror: assert property (p_wr_mirror) else $error("write not mirrored on A");

  property p_wr_then_rd;
    @(posedge clk) disable iff (!rst_b)
      (wrA && !wrB) ##1 (rdA && reqA.addr == $past(reqA.addr)) |=> doutA == $past(dinA, 2);
  endproperty
  a_wr_then_rd: assert property (p_wr_then_rd) else $error("stored word lost on A");

  property p_rd_word;
    @(posedge clk) disable iff (!rst_b)
      rdA |=> doutA == $past(rdWordA);
  endproperty
  a_rd_word: assert property (p_rd_word) else $error("read word wrong on A");

  property p_idle_hold;
    @(posedge clk) disable iff (!rst_b)
      !reqA.en |=> $stable(doutA);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("A output moved without access");

  property p_independent;
    @(posedge clk) disable iff (!rst_b)
      (reqB.en && !reqA.en) |=> $stable(doutA);
  endproperty
  a_independent: assert property (p_independent) else $error("port B disturbed A output");

  property p_wr_one_edge;
    @(posedge clk) disable iff (!rst_b)
      (wrA && !reqB.en) |=> mem_r[$past(baseA) +: WIDTH_A] == $past(dinA);
  endproperty
  a_wr_one_edge: assert property (p_wr_one_edge) else $error("A write not stored");

  property p_rd_one_edge_b;
    @(posedge clk) disable iff (!rst_b)
      rdB |=> doutB == $past(rdWordB);
  endproperty
  a_rd_one_edge_b: assert property (p_rd_one_edge_b) else $error("read word wrong on B");

  property p_hold_two;
    @(posedge clk) disable iff (!rst_b)
      !reqB.en ##1 !reqB.en |=> doutB == $past(doutB, 2);
  endproperty
  a_hold_two: assert property (p_hold_two) else $error("B output not held");

  property p_wr_b_mirror;
    @(posedge clk) disable iff (!rst_b)
      mirB |=> doutB == $past(dinB);
  endproperty
  a_wr_b_mirror: assert property (p_wr_b_mirror) else $error("write not mirrored on B");

  property p_idle_hold_b;
    @(posedge clk) disable iff (!rst_b)
      !reqB.en |=> $stable(doutB);
  endproperty
  a_idle_hold_b: assert property (p_idle_hold_b) else $error("B output moved");

  property p_independent_b;
    @(posedge clk) disable iff (!rst_b)
      (reqA.en && !reqB.en) |=> $stable(doutB);
  endproperty
  a_independent_b: assert property (p_independent_b) else $error("port A disturbed B");

  property p_wr_one_edge_b;
    @(posedge clk) disable iff (!rst_b)
      (wrB && !wrA) |=> mem_r[$past(baseB) +: WIDTH_B] == $past(dinB);
  endproperty
  a_wr_one_edge_b: assert property (p_wr_one_edge_b) else $error("B write not stored");

  property p_rd_through_a;
    @(posedge clk) disable iff (!rst_b)
      (rdA && !wrB) |=> doutA == mem_r[$past(baseA) +: WIDTH_A];
  endproperty
  a_rd_through_a: assert property (p_rd_through_a) else $error("A read not from cells");

  property p_rd_through_b;
    @(posedge clk) disable iff (!rst_b)
      (rdB && !wrA) |=> doutB == mem_r[$past(baseB) +: WIDTH_B];
  endproperty
  a_rd_through_b: assert property (p_rd_through_b) else $error("B read not from cells");

  property p_hold_two_a;
    @(posedge clk) disable iff (!rst_b)
      !reqA.en ##1 !reqA.en |=> doutA == $past(doutA, 2);
  endproperty
  a_hold_two_a: assert property (p_hold_two_a) else $error("A output not held");

  property p_change_cause_a;
    @(posedge clk) disable iff (!rst_b)
      $changed(doutA) |-> $past(reqA.en) || !$past(rst_b);
  endproperty
  a_change_cause_a: assert property (p_change_cause_a) else $error("A changed, no access");

  property p_change_cause_b;
    @(posedge clk) disable iff (!rst_b)
      $changed(doutB) |-> $past(reqB.en) || !$past(rst_b);
  endproperty
  a_change_cause_b: assert property (p_change_cause_b) else $error("B changed, no access");

  property p_mirror_stored_a;
    @(posedge clk) disable iff (!rst_b)
      (mirA && !wrB) |=> doutA == mem_r[$past(baseA) +: WIDTH_A];
  endproperty
  a_mirror_stored_a: assert property (p_mirror_stored_a) else $error("A mirror not stored");

  c_wr_rd_a: cover property (@(posedge clk) disable iff (!rst_b) wrA ##1 rdA);
  c_both_wr: cover property (@(posedge clk) disable iff (!rst_b) wrA && wrB);
  c_rd_both: cover property (@(posedge clk) disable iff (!rst_b) rdA && rdB);
  c_wr_a_rd_b: cover property (@(posedge clk) disable iff (!rst_b) wrA ##1 rdB);
  c_mirror_b: cover property (@(posedge clk) disable iff (!rst_b) mirB);

endmodule

`default_nettype wire

// [core/dpr_pkg.sv]
// Purpose: Shared constants and types for the dual-port block memory
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Port widths must divide the cell count evenly
package dpr_pkg;

  // Total storage in bit cells
  localparam int unsigned MEM_BITS  = 4096;
  // Address field wide enough for the narrowest (1-bit) port
  localparam int unsigned ADDR_W    = $clog2(MEM_BITS);
  // Widest data word a port may use
  localparam int unsigned DATA_MAX  = 16;
  // Default port widths
  localparam int unsigned WIDTH_A_D = 16;
  localparam int unsigned WIDTH_B_D = 8;
  // Output value after reset
  localparam logic [DATA_MAX-1:0] DOUT_RST = 16'h0000;

  // Port function
  typedef enum logic [1:0] {
    DPR_READ_WRITE,
    DPR_READ_ONLY,
    DPR_WRITE_ONLY
  } dprMode_t;

  // One port's request, sampled on the clock edge
  typedef struct packed {
    logic                en;
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_MAX-1:0] din;
  } dprReq_t;

endpackage

// [verif/dpr_user_model.sv]
// Purpose: Fabric user logic standing on port B of the block memory
// Assumes: Requests change on the falling edge, one edge each
// Notes:   Released addr and din show the inverse of the last value; en and we drop to 0
`timescale 1ns/10ps
`default_nettype none
module dpr_user_model
  import dpr_pkg::*;
(
  input  wire logic    clk,
  output var  dprReq_t req
);
  initial req = '0;
  // One access, then idle; caller never writes cells port A writes that edge
  task automatic put(input logic we, input logic [ADDR_W-1:0] a,
                     input logic [DATA_MAX-1:0] d);
    @(negedge clk);
    req = '{en: 1'b1, we: we, addr: a, din: d};
    @(negedge clk);
    req = '{en: 1'b0, we: 1'b0, addr: ~a, din: ~d};
  endtask
endmodule
`default_nettype wire

// [verif/dual_port_block_ram_tb_top.sv]
// Purpose: Self-checking bench for the dual-port block memory
// Assumes: Inputs change on the falling edge
// Notes:   Port A 16 bits, port B 8 bits over shared cells
`timescale 1ns/10ps
`default_nettype none
module dual_port_block_ram_tb_top;
  import dpr_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_b = 1'b0;
  dprReq_t     reqA  = '0;
  dprReq_t     reqB;
  logic [15:0] doutA;
  logic [7:0]  doutB;
  int          num_errors   = 0;
  int          total_checks = 0;
  always #20 clk = ~clk;
  dpr_block_ram dpr_block_ram_i (.clk(clk), .rst_b(rst_b), .reqA(reqA), .reqB(reqB),
                                 .doutA(doutA), .doutB(doutB));
  dpr_user_model dpr_user_model_i (.clk(clk), .req(reqB));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic putA(input logic we, input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    reqA = '{en: 1'b1, we: we, addr: a, din: d};
    @(negedge clk);
    reqA = '{en: 1'b0, we: 1'b0, addr: ~a, din: ~d};
  endtask
  task automatic sc_write_hold();
    putA(1'b1, 12'h003, 16'hbeef);
    chk(doutA, 16'hbeef);
    repeat (3) @(negedge clk);
    chk(doutA, 16'hbeef);
  endtask
  task automatic sc_cross_width();
    dpr_user_model_i.put(1'b0, 12'h006, 16'h0000);
    chk({8'h00, doutB}, 16'h00ef);
    dpr_user_model_i.put(1'b0, 12'h007, 16'h0000);
    chk({8'h00, doutB}, 16'h00be);
    putA(1'b0, 12'h003, 16'h0000);
    chk(doutA, 16'hbeef);
  endtask
  task automatic sc_same_edge();
    fork
      putA(1'b0, 12'h003, 16'h5555);
      dpr_user_model_i.put(1'b1, 12'h006, 16'h0012);
    join
    chk(doutA, 16'hbeef);
    chk({8'h00, doutB}, 16'h0012);
    putA(1'b0, 12'h003, 16'h0000);
    chk(doutA, 16'hbe12);
  endtask
  task automatic sc_back_to_back();
    fork
      begin
        @(negedge clk);
        reqA = '{en: 1'b1, we: 1'b1, addr: 12'h004, din: 16'h5678};
        @(negedge clk);
        chk(doutA, 16'h5678);
        reqA = '{en: 1'b1, we: 1'b1, addr: 12'h005, din: 16'h1234};
        @(negedge clk);
        chk(doutA, 16'h1234);
        reqA = '{en: 1'b1, we: 1'b0, addr: 12'h005, din: 16'h0000};
        @(negedge clk);
        chk(doutA, 16'h1234);
        reqA = '{en: 1'b1, we: 1'b0, addr: 12'h004, din: 16'h0000};
        @(negedge clk);
        chk(doutA, 16'h5678);
        reqA = '{en: 1'b0, we: 1'b0, addr: 12'hffb, din: 16'hffff};
      end
      begin
        dpr_user_model_i.put(1'b1, 12'h00c, 16'h00aa);
        chk({8'h00, doutB}, 16'h00aa);
        dpr_user_model_i.put(1'b0, 12'h008, 16'h0000);
        chk({8'h00, doutB}, 16'h0078);
      end
    join
  endtask
  task automatic sc_mid_reset();
    @(negedge clk);
    rst_b = 1'b0;
    @(negedge clk);
    chk(doutA, 16'h0000);
    chk({8'h00, doutB}, 16'h0000);
    rst_b = 1'b1;
    putA(1'b0, 12'h004, 16'h0000);
    chk(doutA, 16'h5678);
  endtask
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    chk(doutA, 16'h0000);
    chk({8'h00, doutB}, 16'h0000);
    rst_b = 1'b1;
    sc_write_hold();
    sc_cross_width();
    sc_same_edge();
    sc_back_to_back();
    sc_mid_reset();
    close_out();
  end
endmodule
`default_nettype wire
